// ### design/bpw_port.sv
// Five bidirectional ports with direction control, pull-ups and port A wake-up.
// Assumes a one-cycle register port from the core and a free-running clock.
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "bpw_defines.svh"

// Behaviour
// - Direction bit one makes the pin input, zero makes it a driven output.
// - Data writes go to an output latch that holds until rewritten.
// - Pull-up only on input pins, enabled per port by a fixed option.
// - Halt enters power-down; the core clock stops until a wake source.
// - In power-down a selected port A pin falling high to low resumes.
// - Each port A pin has its own wake-up enable option.
// - Direction bits can be set and cleared singly as well as byte-wide.
// - Thirty-two to forty lines in five ports A to E.
// - Direction may change either way at any time.
// - Each data register writes output latches and reads input pin data.
// - Reading an output pin returns its latch, not the pin level.
// - Reset sets all data and direction registers to all ones.
// - Bit set or clear reads the whole port, modifies, writes it back.
module bpw_port
    import bpw_pkg::*;
#(
    parameter int NUM_PINS = 40
)
(
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic ce_in,
    // Register port
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic bit_set_in,
    input wire logic bit_clr_in,
    input wire logic [2:0] bit_index_in,
    output logic [7:0] rdata_out,
    // Power control
    input wire logic halt_in,
    output logic core_run_out,
    // Fixed options
    input wire logic [`BPW_PORT_COUNT-1:0] pullup_option_in,
    input wire logic [`BPW_PORT_WIDTH-1:0] wake_option_in,
    // Pins
    input wire logic [`BPW_MAX_PINS-1:0] pad_in,
    output logic [`BPW_MAX_PINS-1:0] pad_out,
    output logic [`BPW_MAX_PINS-1:0] pad_oe_n_out,
    output logic [`BPW_MAX_PINS-1:0] pull_enable_out,
    // Interrupt
    output logic irq_out
);

    // ==========================================================
    // Constants and helpers
    // Pins above NUM_PINS do not exist on smaller variants
    localparam logic [`BPW_MAX_PINS-1:0] PIN_MASK = {`BPW_MAX_PINS{1'b1}} >>
        (`BPW_MAX_PINS - NUM_PINS);

    function automatic bpw_kind_type decode_kind(input logic [7:0] a);
        if (a >= `BPW_ADDR_DATA_BASE && a < `BPW_ADDR_DIR_BASE)
            return BPW_KIND_DATA;
        else if (a >= `BPW_ADDR_DIR_BASE && a < `BPW_ADDR_WAKE_STATUS)
            return BPW_KIND_DIR;
        else if (a == `BPW_ADDR_WAKE_STATUS)
            return BPW_KIND_STATUS;
        else if (a == `BPW_ADDR_WAKE_MASK)
            return BPW_KIND_MASK;
        else if (a == `BPW_ADDR_POWER)
            return BPW_KIND_POWER;
        else
            return BPW_KIND_NONE;
    endfunction

    function automatic logic [5:0] port_offset(input logic [7:0] a);
        logic [7:0] rel;
        rel = (a < `BPW_ADDR_DIR_BASE) ? a - `BPW_ADDR_DATA_BASE : a - `BPW_ADDR_DIR_BASE;
        return {rel[2:0], 3'h0};
    endfunction

    // Inputs show the pin, outputs show their own latch
    function automatic logic [7:0] port_view(input logic [7:0] latch, input logic [7:0] dir,
        input logic [7:0] pin);
        return (dir & pin) | (~dir & latch);
    endfunction

    // ==========================================================
    // Pin synchroniser and wake edges
    logic [`BPW_MAX_PINS-1:0] pin_sync;
    logic [`BPW_PORT_WIDTH-1:0] fall_a;
    logic [`BPW_PORT_WIDTH-1:0] wake_hit;

    bpw_pin_sync #(
        .PINS(`BPW_MAX_PINS),
        .WAKE_PINS(`BPW_PORT_WIDTH)
    ) u_sync (
        .sys_clk_in(sys_clk_in),
        .reset_in(reset_in),
        .ce_in(ce_in),
        .pad_in(pad_in),
        .pin_sync_out(pin_sync),
        .fall_out(fall_a)
    );

    assign wake_hit = fall_a & wake_option_in;

    // ==========================================================
    // Register state
    logic [`BPW_MAX_PINS-1:0] port_data_latch;
    logic [`BPW_MAX_PINS-1:0] port_direction;
    logic [`BPW_PORT_WIDTH-1:0] wake_status;
    logic [`BPW_PORT_WIDTH-1:0] wake_mask;
    bpw_power_type power_state;
    logic [7:0] rdata;
    logic [`BPW_MAX_PINS-1:0] next_port_data_latch;
    logic [`BPW_MAX_PINS-1:0] next_port_direction;
    logic [`BPW_PORT_WIDTH-1:0] next_wake_status;
    logic [`BPW_PORT_WIDTH-1:0] next_wake_mask;
    bpw_power_type next_power_state;
    logic [7:0] next_rdata;
    bpw_kind_type kind;
    logic [5:0] offs;
    logic [7:0] cur_byte;
    logic [7:0] new_byte;
    logic any_write;

    always_comb
    begin
        next_port_data_latch = port_data_latch;
        next_port_direction = port_direction;
        next_wake_mask = wake_mask;
        next_power_state = power_state;
        next_rdata = 8'h00;
        kind = decode_kind(addr_in);
        offs = port_offset(addr_in);
        any_write = wr_in | bit_set_in | bit_clr_in;
        // Port read value; unbuilt pins read as zero
        if (kind == BPW_KIND_DATA)
            cur_byte = port_view(port_data_latch[offs +: 8], port_direction[offs +: 8],
                pin_sync[offs +: 8]) & PIN_MASK[offs +: 8];
        else if (kind == BPW_KIND_DIR)
            cur_byte = port_direction[offs +: 8] & PIN_MASK[offs +: 8];
        else if (kind == BPW_KIND_STATUS)
            cur_byte = wake_status;
        else if (kind == BPW_KIND_MASK)
            cur_byte = wake_mask;
        else if (kind == BPW_KIND_POWER)
            cur_byte = {7'h00, power_state == BPW_DOWN};
        else
            cur_byte = 8'h00;
        // Bit operations rewrite the whole byte; input pins copy their level into the latch
        if (bit_set_in)
            new_byte = cur_byte | (8'h01 << bit_index_in);
        else if (bit_clr_in)
            new_byte = cur_byte & ~(8'h01 << bit_index_in);
        else
            new_byte = wdata_in;
        if (any_write && kind == BPW_KIND_DATA)
            next_port_data_latch[offs +: 8] = new_byte;
        if (any_write && kind == BPW_KIND_DIR)
            next_port_direction[offs +: 8] = new_byte;
        if (any_write && kind == BPW_KIND_MASK)
            next_wake_mask = new_byte;
        // Write one to clear; a new edge in the same cycle survives
        next_wake_status = wake_status;
        if (any_write && kind == BPW_KIND_STATUS)
            next_wake_status = wake_status & ~new_byte;
        next_wake_status = next_wake_status | wake_hit;
        if (rd_in)
            next_rdata = cur_byte;
        unique case (power_state)
            BPW_RUN:
                if (halt_in && wake_hit == 8'h00)
                    next_power_state = BPW_DOWN;
            BPW_DOWN:
                if (wake_hit != 8'h00)
                    next_power_state = BPW_RUN;
        endcase
    end

    always_ff @(posedge sys_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            port_data_latch <= {`BPW_PORT_COUNT{`BPW_RESET_PORT}};
            port_direction <= {`BPW_PORT_COUNT{`BPW_RESET_PORT}};
            wake_status <= `BPW_RESET_MASK;
            wake_mask <= `BPW_RESET_MASK;
            power_state <= BPW_RUN;
            rdata <= 8'h00;
        end
        else if (ce_in)
        begin
            port_data_latch <= next_port_data_latch;
            port_direction <= next_port_direction;
            wake_status <= next_wake_status;
            wake_mask <= next_wake_mask;
            power_state <= next_power_state;
            rdata <= next_rdata;
        end
    end

    // ==========================================================
    // Pin drive and pull-ups
    logic [`BPW_MAX_PINS-1:0] pull_option_bits;

    always_comb
    begin
        for (int p = 0; p < `BPW_PORT_COUNT; p++)
            pull_option_bits[p*8 +: 8] = {8{pullup_option_in[p]}};
    end

    assign pad_out = port_data_latch & PIN_MASK;
    assign pad_oe_n_out = port_direction | ~PIN_MASK;
    assign pull_enable_out = port_direction & pull_option_bits & PIN_MASK;
    assign rdata_out = rdata;
    assign core_run_out = (power_state == BPW_RUN);
    assign irq_out = |(wake_status & wake_mask);

    // ==========================================================
    // Checks
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (reset_in);

    dir_write_a: assert property (
        (ce_in && wr_in && addr_in == `BPW_ADDR_DIR_BASE) |=> pad_oe_n_out[7:0] == $past(wdata_in))
        else $error("direction write not applied to pin enables");
    latch_write_a: assert property (
        (ce_in && wr_in && addr_in == `BPW_ADDR_DATA_BASE) |=> pad_out[7:0] == $past(wdata_in))
        else $error("data write not applied to output latch");
    latch_hold_a: assert property (
        (!wr_in && !bit_set_in && !bit_clr_in) |=> $stable(pad_out))
        else $error("output latch changed without a write");
    pull_input_a: assert property (
        (pull_enable_out & ~pad_oe_n_out) == 40'h00_0000_0000)
        else $error("pull-up on a driven pin");
    halt_down_a: assert property (
        (ce_in && halt_in && core_run_out && wake_hit == 8'h00) |=> !core_run_out)
        else $error("halt did not stop the core");
    wake_run_a: assert property (
        (ce_in && !core_run_out && wake_hit != 8'h00) |=> core_run_out)
        else $error("selected falling edge did not wake");
    wake_masked_a: assert property (
        (!core_run_out && !(ce_in && wake_hit != 8'h00)) |=> !core_run_out)
        else $error("woke without a selected edge");
    read_view_a: assert property (
        (ce_in && rd_in && addr_in == `BPW_ADDR_DATA_BASE) |=> rdata_out ==
        $past((pin_sync[7:0] & port_direction[7:0]) | (~port_direction[7:0] &
        port_data_latch[7:0])))
        else $error("port read returned wrong mix of pins and latch");
    bit_set_dir_a: assert property (
        (ce_in && bit_set_in && addr_in == `BPW_ADDR_DIR_BASE) |=> pad_oe_n_out[7:0] ==
        $past(port_direction[7:0] | (8'h01 << bit_index_in)))
        else $error("bit set on direction register wrong");
    unbuilt_pins_a: assert property (
        (pad_oe_n_out | PIN_MASK) == {`BPW_MAX_PINS{1'b1}})
        else $error("unbuilt pin driven");
    reset_high_a: assert property (@(posedge sys_clk_in) disable iff (1'b0)
        reset_in |-> (pad_oe_n_out == {`BPW_MAX_PINS{1'b1}} && pad_out == PIN_MASK))
        else $error("reset did not set ports high");
    ce_freeze_a: assert property (
        !ce_in |=> $stable(pad_out) && $stable(pad_oe_n_out) && $stable(core_run_out) &&
        $stable(rdata_out) && $stable(irq_out))
        else $error("state moved while the clock enable was low");
    rdata_idle_a: assert property (
        (ce_in && !rd_in) |=> rdata_out == 8'h00)
        else $error("read data not zero outside the read answer cycle");
    // Set wins over a write-one clear in the same cycle
    wake_set_a: assert property (
        (ce_in && wake_hit != 8'h00) |=> (wake_status & $past(wake_hit)) == $past(wake_hit))
        else $error("selected falling edge not recorded in wake status");
    wake_ignored_a: assert property (
        ce_in |=> (wake_status & ~$past(wake_status) & ~$past(wake_option_in)) == 8'h00)
        else $error("wake status set for a pin whose wake option is off");
    status_clear_a: assert property (
        (ce_in && wr_in && addr_in == `BPW_ADDR_WAKE_STATUS && wake_hit == 8'h00) |=>
        (wake_status & $past(wdata_in)) == 8'h00)
        else $error("wake status bit not cleared by writing a one");
    // Input bits copy the pin level into the latch, as the whole port is rewritten
    bit_clr_data_a: assert property (
        (ce_in && bit_clr_in && addr_in == `BPW_ADDR_DATA_BASE) |=> pad_out[7:0] ==
        $past(port_view(port_data_latch[7:0], port_direction[7:0], pin_sync[7:0]) &
        ~(8'h01 << bit_index_in)))
        else $error("bit clear on port data did not rewrite the read view");
    bit_clr_dir_a: assert property (
        (ce_in && bit_clr_in && addr_in == `BPW_ADDR_DIR_BASE) |=> pad_oe_n_out[7:0] ==
        $past(port_direction[7:0] & ~(8'h01 << bit_index_in)))
        else $error("bit clear on direction register wrong");
    halt_idle_a: assert property (
        (core_run_out && !(ce_in && halt_in)) |=> core_run_out)
        else $error("core stopped without a halt");

    // ==========================================================
    // Cover points
    wake_cycle_c: cover property (halt_in ##[1:50] core_run_out);
    bit_clear_c: cover property (bit_clr_in && addr_in == `BPW_ADDR_DATA_BASE);
    input_read_c: cover property (rd_in && port_direction[0] && !pin_sync[0]);
    status_clear_c: cover property (wr_in && addr_in == `BPW_ADDR_WAKE_STATUS);
    frozen_write_c: cover property (!ce_in && wr_in);

endmodule

// ### design/bpw_defines.svh
// Register map, reset values and sizes for the bidirectional port block.
// Assumes inclusion by bare name from design files.
`ifndef BPW_DEFINES_SVH
`define BPW_DEFINES_SVH

// ==========================================================
// Register offsets
`define BPW_ADDR_DATA_BASE 8'h00
`define BPW_ADDR_DIR_BASE 8'h05
`define BPW_ADDR_WAKE_STATUS 8'h0A
`define BPW_ADDR_WAKE_MASK 8'h0B
`define BPW_ADDR_POWER 8'h0C

// ==========================================================
// Sizes and reset values
`define BPW_PORT_COUNT 5
`define BPW_PORT_WIDTH 8
`define BPW_MAX_PINS 40
`define BPW_RESET_PORT 8'hFF
`define BPW_RESET_MASK 8'h00
`define BPW_POWER_BIT 0

`endif

// ### design/bpw_pkg.sv
// Types shared by the bidirectional port block.
// Assumes nothing beyond a SystemVerilog compiler.
package bpw_pkg;

    // ==========================================================
    // Register kinds and power states
    typedef enum logic [2:0] {BPW_KIND_DATA, BPW_KIND_DIR, BPW_KIND_STATUS, BPW_KIND_MASK,
        BPW_KIND_POWER, BPW_KIND_NONE} bpw_kind_type;

    typedef enum logic {BPW_RUN, BPW_DOWN} bpw_power_type;

endpackage

// ### design/bpw_pin_sync.sv
// Pin synchroniser and falling-edge finder for the wake-capable pins.
// Assumes sys_clk_in is the free-running oscillator; only the core is gated.
`timescale 1ns/1ps

module bpw_pin_sync
    import bpw_pkg::*;
#(
    parameter int PINS = 40,
    parameter int WAKE_PINS = 8
)
(
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic ce_in,
    // Pins
    input wire logic [PINS-1:0] pad_in,
    // Results
    output logic [PINS-1:0] pin_sync_out,
    output logic [WAKE_PINS-1:0] fall_out
);

    // ==========================================================
    // Two-stage synchroniser and edge history
    logic [PINS-1:0] meta;
    logic [PINS-1:0] sync;
    logic [WAKE_PINS-1:0] prev;
    logic [PINS-1:0] next_meta;
    logic [PINS-1:0] next_sync;
    logic [WAKE_PINS-1:0] next_prev;
    logic [1:0] settle;
    logic [1:0] next_settle;

    always_comb
    begin
        next_meta = pad_in;
        next_sync = meta;
        next_prev = sync[WAKE_PINS-1:0];
        next_settle = (settle == 2'h3) ? settle : settle + 2'h1;
    end

    // Reset to the idle high level of a pulled-up wake pin
    always_ff @(posedge sys_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            meta <= '1;
            sync <= '1;
            prev <= '1;
            settle <= 2'h0;
        end
        else if (ce_in)
        begin
            meta <= next_meta;
            sync <= next_sync;
            prev <= next_prev;
            settle <= next_settle;
        end
    end

    // ==========================================================
    // Outputs
    assign pin_sync_out = sync;
    // Edges count only once prev holds a sampled level, so a pin held low through
    // reset is no fall; a real fall before the first sample after reset is lost
    assign fall_out = (prev & ~sync[WAKE_PINS-1:0]) & {WAKE_PINS{settle == 2'h3}};

endmodule

// ### dv/bpw_switch_model.sv
// Model of the switches and circuitry that sit on the port pins.
// Assumes switches pull a pin to ground when closed; open pins float.
`timescale 1ns/1ps

module bpw_switch_model
(
    // Clock
    input wire logic sys_clk_in,
    // Device side of the pins
    input wire logic [39:0] pad_out_in,
    input wire logic [39:0] pad_oe_n_in,
    input wire logic [39:0] pull_enable_in,
    // Commanded switches
    input wire logic [39:0] switch_closed_in,
    // Resolved pin levels
    output logic [39:0] pad_level_out
);
    // ==========================================================
    // Floating level
    // An undriven, unpulled pin toggles so a stale value never reads as valid
    logic [39:0] float_level = 40'h55_5555_5555;

    always @(posedge sys_clk_in)
        float_level <= ~float_level;

    // ==========================================================
    // Pin resolution
    // Driven and pulled levels are held steadily; an undriven, unpulled pin follows the toggling float level
    assign pad_level_out = (~pad_oe_n_in & pad_out_in)
        | (pad_oe_n_in & ~switch_closed_in & (pull_enable_in | float_level));
endmodule

// ### dv/testbench.sv
// Self-checking bench for the five-port block, driven through its register port.
// Assumes the switch model on the pins and a free-running 40 MHz clock.
`timescale 1ns/1ps
`include "bpw_defines.svh"

module testbench
    import bpw_pkg::*;
;
    // ==========================================================
    // Signals
    logic sys_clk = 1'b0;
    logic reset = 1'b0;
    logic ce = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic bset = 1'b0;
    logic bclr = 1'b0;
    logic [2:0] bidx = 3'h0;
    logic halt = 1'b0;
    logic [39:0] sw = 40'h0;
    logic [7:0] rdata;
    logic core_run;
    logic irq;
    logic [39:0] pad_out;
    logic [39:0] pad_oe_n;
    logic [39:0] pull_en;
    logic [39:0] pad_level;
    int n_errors = 0;
    int checks_done = 0;

    always #12.5 sys_clk = ~sys_clk;

    bpw_port #(.NUM_PINS(40)) u_dut (.sys_clk_in(sys_clk), .reset_in(reset), .ce_in(ce),
        .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .bit_set_in(bset),
        .bit_clr_in(bclr), .bit_index_in(bidx), .rdata_out(rdata), .halt_in(halt),
        .core_run_out(core_run), .pullup_option_in(5'h1D), .wake_option_in(8'h05),
        .pad_in(pad_level), .pad_out(pad_out), .pad_oe_n_out(pad_oe_n),
        .pull_enable_out(pull_en), .irq_out(irq));

    bpw_switch_model u_sw (.sys_clk_in(sys_clk), .pad_out_in(pad_out),
        .pad_oe_n_in(pad_oe_n), .pull_enable_in(pull_en), .switch_closed_in(sw),
        .pad_level_out(pad_level));

    // ==========================================================
    // Tasks
    task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
        checks_done++;
        if (g !== e)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
        #1;
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 chk(nm, e, rdata);
    endtask

    task automatic bit_op(input logic s, input logic [7:0] a, input logic [2:0] i);
        @(posedge sys_clk);
        addr <= a;
        bidx <= i;
        bset <= s;
        bclr <= ~s;
        @(posedge sys_clk);
        bset <= 1'b0;
        bclr <= 1'b0;
        #1;
    endtask

    task automatic summarize;
        if (n_errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ==========================================================
    // Tests
    initial
    begin
        // Raised by a nonblocking assignment at time zero so the asynchronous reset sees an edge
        reset <= 1'b1;
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
        #1 chk("pad_oe_n", 40'hFF_FFFF_FFFF, pad_oe_n);
        chk("pad_out", 40'hFF_FFFF_FFFF, pad_out);
        chk("pull_en", 40'hFF_FFFF_00FF, pull_en);
        for (int p = 0; p < 5; p++)
            rd_chk("dir", `BPW_ADDR_DIR_BASE + 8'(p), 8'hFF);
        rd_chk("port_c", `BPW_ADDR_DATA_BASE + 8'h02, 8'hFF);
        rd_chk("unmapped", 8'h20, 8'h00);
        // Power-down, then wake only from an enabled port A pin
        @(posedge sys_clk);
        halt <= 1'b1;
        @(posedge sys_clk);
        halt <= 1'b0;
        #1 chk("core_run", 0, core_run);
        rd_chk("power", `BPW_ADDR_POWER, 8'h01);
        @(posedge sys_clk);
        #1 chk("rdata_idle", 8'h00, rdata);
        sw[1] <= 1'b1;
        repeat (6) @(posedge sys_clk);
        #1 chk("core_run", 0, core_run);
        sw[2] <= 1'b1;
        repeat (5) @(posedge sys_clk);
        #1 chk("core_run", 1, core_run);
        chk("irq", 0, irq);
        rd_chk("status", `BPW_ADDR_WAKE_STATUS, 8'h04);
        wr_reg(`BPW_ADDR_WAKE_MASK, 8'h04);
        chk("irq", 1, irq);
        wr_reg(`BPW_ADDR_WAKE_STATUS, 8'h04);
        chk("irq", 0, irq);
        sw[2:1] <= 2'b00;
        // Mixed direction on port A; direction is set before data
        wr_reg(`BPW_ADDR_DIR_BASE, 8'h0F);
        wr_reg(`BPW_ADDR_DATA_BASE, 8'hA5);
        chk("pad_out_a", 8'hA5, pad_out[7:0]);
        chk("oe_n_a", 8'h0F, pad_oe_n[7:0]);
        chk("pull_a", 8'h0F, pull_en[7:0]);
        sw[0] <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rd_chk("port_a", `BPW_ADDR_DATA_BASE, 8'hAE);
        bit_op(1'b1, `BPW_ADDR_DIR_BASE, 3'd7);
        chk("oe_n_a", 8'h8F, pad_oe_n[7:0]);
        bit_op(1'b0, `BPW_ADDR_DATA_BASE, 3'd5);
        chk("pad_out_a", 8'h8E, pad_out[7:0]);
        bit_op(1'b0, `BPW_ADDR_DIR_BASE, 3'd0);
        chk("oe_n_a", 8'h8E, pad_oe_n[7:0]);
        chk("pull_a", 8'h8E, pull_en[7:0]);
        // All five ports as outputs; the latch reads back
        for (int p = 0; p < 5; p++)
        begin
            wr_reg(`BPW_ADDR_DIR_BASE + 8'(p), 8'h00);
            wr_reg(`BPW_ADDR_DATA_BASE + 8'(p), 8'(8'h11 * (p + 1)));
            rd_chk("port", `BPW_ADDR_DATA_BASE + 8'(p), 8'(8'h11 * (p + 1)));
        end
        chk("pad_out", 40'h55_4433_2211, pad_out);
        chk("pad_oe_n", 40'h0, pad_oe_n);
        wr_reg(`BPW_ADDR_DIR_BASE + 8'h04, 8'hFF);
        chk("oe_n_e", 8'hFF, pad_oe_n[39:32]);
        // A write with the clock enable low is not taken
        @(posedge sys_clk);
        ce <= 1'b0;
        addr <= `BPW_ADDR_DATA_BASE + 8'h04;
        wdata <= 8'h00;
        wr <= 1'b1;
        @(posedge sys_clk);
        ce <= 1'b1;
        wr <= 1'b0;
        #1 chk("frozen_e", 8'h55, pad_out[39:32]);
        // Reset in mid-run; pin 0's switch stays closed, so the pin is held low through reset and must not read as a wake edge
        @(posedge sys_clk);
        reset <= 1'b1;
        @(posedge sys_clk);
        reset <= 1'b0;
        #1 chk("pad_out", 40'hFF_FFFF_FFFF, pad_out);
        chk("pad_oe_n", 40'hFF_FFFF_FFFF, pad_oe_n);
        repeat (4) @(posedge sys_clk);
        rd_chk("status", `BPW_ADDR_WAKE_STATUS, 8'h00);
        rd_chk("port_a", `BPW_ADDR_DATA_BASE, 8'hFE);
        summarize();
    end

    // ==========================================================
    // Watchdog
    initial
    begin
        #50us;
        n_errors++;
        summarize();
    end
endmodule
